// [hw/irq_agg_pkg.sv]
package irq_agg_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  ENABLE_SFR_ADDR = 8'ha8;
  localparam logic [15:0] VECTOR_ADDR     = 16'hff92;
  localparam logic [7:0]  ENABLE_RESET    = 8'h00;
  localparam logic [7:0]  ENABLE_RSV_MASK = 8'h9f;
  localparam logic [7:0]  NO_VECTOR       = 8'h00;

  // enable register fields
  localparam int EXT0_IRQ_BIT   = 0;
  localparam int TIMER0_IRQ_BIT = 1;
  localparam int EXT1_IRQ_BIT   = 2;
  localparam int TIMER1_IRQ_BIT = 3;
  localparam int SERIAL_IRQ_BIT = 4;
  localparam int GLOBAL_GATE_BIT = 7;
  localparam int NCORE = 5;

  // ----------------------------------------
  // core entry addresses, by enable bit
  // ----------------------------------------
  localparam logic [15:0] RESET_ENTRY = 16'h0000;
  localparam logic [15:0] CORE_ENTRY [NCORE] =
    '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023};

  // ----------------------------------------
  // peripheral sources and their vectors
  // ----------------------------------------
  localparam int NSRC = 22;
  localparam logic [7:0] SRC_VEC [NSRC] = '{
    8'h12, 8'h14, 8'h16,                // out endpoints 1..3
    8'h22, 8'h24, 8'h26,                // in endpoints 1..3
    8'h30, 8'h32,                       // setup_overwrite, setup rx
    8'h38, 8'h3a, 8'h3c, 8'h3e,         // resume, suspend, reset, wake
    8'h40, 8'h42, 8'h44, 8'h46,         // i2c tx/rx, ep0 in/out
    8'h50, 8'h52, 8'h60, 8'h62,         // uart status, modem, rx, tx
    8'h80, 8'h84};                      // dma1, dma3
  localparam int I2C_TX_SRC = 12;
  localparam int I2C_RX_SRC = 13;
  localparam logic I2C_TX_EMPTY_RESET = 1'b1;

  typedef struct packed {
    logic        take;
    logic [15:0] addr;
  } core_entry_s;

endpackage

// [hw/vectored_interrupt_aggregator.sv]
// What this block does
// - OR all peripheral requests onto ext0
// - core entries at fixed addresses 0003h-0023h
// - ext0 entry serves all peripherals via vector
// - enable bits 0..4, bits 5,6 reserved
// - bit 7 gates every interrupt globally
// - ext0 is edge-triggered after reset
// - 8-bit vector, 22 sources, hardwired encoder
// - any vector write retires, next one shows
// - vector bit 0 always reads zero
// - vector reads 00h when nothing pending
// - bits 3:1 index, first come first served
// - bits 7:4 group, higher group wins
// - fixed group priority, arrival order within a group
// - usb endpoint, setup, bus event vectors
// - i2c, ep0, uart, dma vectors
// - i2c empty and full flags are sources
module vectored_interrupt_aggregator
  import irq_agg_pkg::*;
#(
  parameter int VEC_W = 8
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // special function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  output      logic [7:0]        sfr_rdata,
  // external data space port
  input  wire logic [15:0]       xdata_addr,
  input  wire logic              xdata_wr,
  output      logic [VEC_W-1:0]  xdata_rdata,
  // peripheral request levels, index order of SRC_VEC
  input  wire logic [NSRC-1:0]   periph_req,
  // i2c flag events
  input  wire logic              i2c_byte_to_shift,
  input  wire logic              i2c_dout_written,
  input  wire logic              i2c_byte_loaded,
  input  wire logic              i2c_din_read,
  output      logic              transmit_empty_flag,
  output      logic              receive_full_flag,
  // core side
  input  wire logic [NCORE-1:1]  core_req,
  input  wire logic              ext0_mode_wr,
  input  wire logic              ext0_mode_level,
  input  wire logic              ext0_ack,
  output      logic              aggregated_ext_request,
  output      core_entry_s       core_entry
);

  if (VEC_W != 8)
  begin : g_bad_width
    $error("vector width must be 8");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]      core_enable_reg;
  logic [7:0]      next_core_enable_reg;
  logic [NSRC-1:0] req_q;
  logic [NSRC-1:0] next_req_q;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] next_pend;
  logic [NSRC-1:0] beat [NSRC];
  logic [NSRC-1:0] next_beat [NSRC];
  logic [7:0]      pending_source_vector;
  logic [7:0]      next_vector;
  logic            tx_empty;
  logic            next_tx_empty;
  logic            rx_full;
  logic            next_rx_full;
  logic            ext0_level;
  logic            next_ext0_level;
  logic            agg_q;
  logic            next_agg_q;
  logic            ext0_edge;
  logic            next_ext0_edge;
  core_entry_s     next_entry;

  logic [NSRC-1:0] src_lvl;
  logic [NSRC-1:0] arrive;
  logic [NSRC-1:0] elig;
  logic            retire;
  logic            any_pend;
  logic            ext0_req;
  logic [NCORE-1:0] granted;

  function automatic logic [3:0] grp(input int i);
    grp = SRC_VEC[i][7:4];
  endfunction

  // ----------------------------------------
  // register access
  // ----------------------------------------
  assign retire = xdata_wr && (xdata_addr == VECTOR_ADDR);

  always_comb
  begin
    next_core_enable_reg = core_enable_reg;
    if (sfr_wr && (sfr_addr == ENABLE_SFR_ADDR))
      next_core_enable_reg = sfr_wdata & ENABLE_RSV_MASK;
  end

  always_comb
  begin
    sfr_rdata   = 8'h00;
    xdata_rdata = 8'h00;
    if (sfr_addr == ENABLE_SFR_ADDR)
      sfr_rdata = core_enable_reg;
    if (xdata_addr == VECTOR_ADDR)
      xdata_rdata = pending_source_vector;
  end

  // ----------------------------------------
  // i2c flags
  // ----------------------------------------
  // set wins over clear when both land together
  always_comb
  begin
    next_tx_empty = tx_empty;
    next_rx_full  = rx_full;
    if (i2c_dout_written)
      next_tx_empty = 1'b0;
    if (i2c_byte_to_shift)
      next_tx_empty = 1'b1;
    if (i2c_din_read)
      next_rx_full = 1'b0;
    if (i2c_byte_loaded)
      next_rx_full = 1'b1;
  end

  assign transmit_empty_flag = tx_empty;
  assign receive_full_flag   = rx_full;

  always_comb
  begin
    src_lvl = periph_req;
    src_lvl[I2C_TX_SRC] = tx_empty;
    src_lvl[I2C_RX_SRC] = rx_full;
  end

  // ----------------------------------------
  // pending capture and arrival order
  // ----------------------------------------
  // a source re-arms only on a new rising edge,
  // so a retired but still high line does not repeat
  assign next_req_q = src_lvl;
  assign arrive     = src_lvl & ~req_q;

  for (genvar i = 0; i < NSRC; i++)
  begin : g_pend
    always_comb
    begin
      next_pend[i] = pend[i];
      if (retire && (pending_source_vector == SRC_VEC[i]))
        next_pend[i] = 1'b0;
      if (arrive[i])
        next_pend[i] = 1'b1;
    end

    // beat[j][i]: j arrived before i
    for (genvar j = 0; j < NSRC; j++)
    begin : g_age
      always_comb
      begin
        next_beat[j][i] = beat[j][i];
        if (arrive[i] && arrive[j])
          next_beat[j][i] = (j < i);
        else if (arrive[i])
          next_beat[j][i] = pend[j];
        else if (arrive[j])
          next_beat[j][i] = 1'b0;
      end
    end

    // only one source can be eligible at a time
    always_comb
    begin
      elig[i] = pend[i];
      for (int j = 0; j < NSRC; j++)
      begin
        if (j != i && pend[j])
        begin
          if (grp(j) > grp(i))
            elig[i] = 1'b0;
          if (grp(j) == grp(i) && beat[j][i])
            elig[i] = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // vector encoder
  // ----------------------------------------
  always_comb
  begin
    next_vector = NO_VECTOR;
    for (int i = 0; i < NSRC; i++)
    begin
      if (elig[i])
        next_vector = next_vector | SRC_VEC[i];
    end
    next_vector[0] = 1'b0;
  end

  // ----------------------------------------
  // core interrupt side
  // ----------------------------------------
  assign any_pend = |pend;
  assign aggregated_ext_request = ~any_pend;
  assign next_agg_q = aggregated_ext_request;

  always_comb
  begin
    next_ext0_level = ext0_level;
    if (ext0_mode_wr)
      next_ext0_level = ext0_mode_level;
    next_ext0_edge = ext0_edge;
    if (ext0_ack)
      next_ext0_edge = 1'b0;
    if (agg_q && !aggregated_ext_request)
      next_ext0_edge = 1'b1;
  end

  // edge mode latches the fall; level mode follows the line
  assign ext0_req = ext0_level ? any_pend : ext0_edge;

  always_comb
  begin
    granted = {core_req, ext0_req};
    for (int k = 0; k < NCORE; k++)
      granted[k] = granted[k] & core_enable_reg[k]
                   & core_enable_reg[GLOBAL_GATE_BIT];
  end

  // ext0 outranks the others when several are granted
  always_comb
  begin
    next_entry.take = |granted;
    next_entry.addr = RESET_ENTRY;
    for (int k = NCORE - 1; k >= 0; k--)
    begin
      if (granted[k])
        next_entry.addr = CORE_ENTRY[k];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      core_enable_reg       <= ENABLE_RESET;
      req_q                 <= '0;
      pend                  <= '0;
      beat                  <= '{default: '0};
      pending_source_vector <= NO_VECTOR;
      tx_empty              <= I2C_TX_EMPTY_RESET;
      rx_full               <= 1'b0;
      ext0_level            <= 1'b0;
      agg_q                 <= 1'b1;
      ext0_edge             <= 1'b0;
      core_entry            <= '0;
    end
    else
    begin
      core_enable_reg       <= next_core_enable_reg;
      req_q                 <= next_req_q;
      pend                  <= next_pend;
      beat                  <= next_beat;
      pending_source_vector <= next_vector;
      tx_empty              <= next_tx_empty;
      rx_full               <= next_rx_full;
      ext0_level            <= next_ext0_level;
      agg_q                 <= next_agg_q;
      ext0_edge             <= next_ext0_edge;
      core_entry            <= next_entry;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_vec_even;
    @(posedge clk_sys) disable iff (rst) pending_source_vector[0] == 1'b0;
  endproperty
  a_vec_even: assert property (p_vec_even) else $error("odd vector");
  property p_idle_zero;
    @(posedge clk_sys) disable iff (rst) (pend == '0) |=> (pending_source_vector == NO_VECTOR);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle vector nonzero");
  property p_agg_low;
    @(posedge clk_sys) disable iff (rst) (aggregated_ext_request == 1'b0) == (pend != '0);
  endproperty
  a_agg_low: assert property (p_agg_low) else $error("ext0 request wrong");
  // dma1 shares the group, so it may legally come first
  property p_dma3_first;
    @(posedge clk_sys) disable iff (rst) (pend[NSRC-1] && !pend[NSRC-2]) |=> (pending_source_vector == 8'h84);
  endproperty
  a_dma3_first: assert property (p_dma3_first) else $error("dma3 not first");
  property p_retire;
    @(posedge clk_sys) disable iff (rst) (retire && pending_source_vector == 8'h12 && !arrive[0]) |=> !pend[0];
  endproperty
  a_retire: assert property (p_retire) else $error("vector not retired");
  property p_rsv_zero;
    @(posedge clk_sys) disable iff (rst) (core_enable_reg[6:5] == 2'b00);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
  property p_gate;
    @(posedge clk_sys) disable iff (rst) !core_enable_reg[GLOBAL_GATE_BIT] |=> !core_entry.take;
  endproperty
  a_gate: assert property (p_gate) else $error("gate leaked");
  // a flag already high makes no new arrival
  property p_tx_flag;
    @(posedge clk_sys) disable iff (rst)
    (i2c_byte_to_shift && !transmit_empty_flag) |=> transmit_empty_flag ##1 pend[I2C_TX_SRC];
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("i2c empty not raised");
  property p_group_order;
    @(posedge clk_sys) disable iff (rst) (pend[20] && pend[0]) |=> (pending_source_vector[7:4] == 4'h8);
  endproperty
  a_group_order: assert property (p_group_order) else $error("group order");

  c_retire: cover property (@(posedge clk_sys) disable iff (rst) retire && pend != '0);
  c_two_in_group: cover property (@(posedge clk_sys) disable iff (rst) pend[0] && pend[1]);
  c_level_mode: cover property (@(posedge clk_sys) disable iff (rst) ext0_level && core_entry.take);
  c_edge_mode: cover property (@(posedge clk_sys) disable iff (rst) ext0_edge && !ext0_level);

endmodule

// [dv/core_model.sv]
module core_model
  import irq_agg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // block side
  input  wire logic        service,
  input  wire logic        aggregated_ext_request,
  input  wire logic [7:0]  xdata_rdata,
  output      logic [15:0] xdata_addr,
  output      logic        xdata_wr,
  output      logic        ext0_mode_wr,
  output      logic        ext0_mode_level,
  // dispatch report
  output      logic        vec_seen,
  output      logic [7:0]  vec_val
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] cnt;
  logic       mode_done;

  assign xdata_addr      = VECTOR_ADDR;
  assign ext0_mode_level = 1'b1;

  // --------------------------------
  // firmware: settle, read, retire
  // --------------------------------
  // waits a few cycles so a just-retired vector has been replaced
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt          <= 3'h0;
      mode_done    <= 1'b0;
      ext0_mode_wr <= 1'b0;
      xdata_wr     <= 1'b0;
      vec_seen     <= 1'b0;
      vec_val      <= 8'h00;
    end
    else
    begin
      // trigger mode keeps its reset default until first service
      ext0_mode_wr <= service && !mode_done;
      mode_done    <= mode_done || service;
      vec_seen     <= (cnt == 3'h3);
      xdata_wr     <= (cnt == 3'h3);
      if (cnt == 3'h3)
        vec_val <= xdata_rdata;
      if (cnt != 3'h0)
        cnt <= cnt + 3'h1;
      else if (service && !aggregated_ext_request)
        cnt <= 3'h1;
    end
  end
endmodule

// [dv/test_vectored_interrupt_aggregator.sv]
module test_vectored_interrupt_aggregator
  import irq_agg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] EXP_VEC [NSRC] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32,
    8'h38, 8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84};
  localparam logic [15:0] EXP_ENTRY [5] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023};

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [NSRC-1:0] periph_req = '0;
  logic [NCORE-1:1] core_req = '0;
  logic i2c_byte_to_shift = 1'b0;
  logic i2c_dout_written = 1'b0;
  logic i2c_byte_loaded = 1'b0;
  logic i2c_din_read = 1'b0;
  logic ext0_ack = 1'b0;
  logic service = 1'b0;
  logic armed = 1'b0;
  logic [7:0] sfr_rdata, xdata_rdata, vec_val, s_rd, s_xd;
  logic [15:0] xdata_addr;
  logic xdata_wr, ext0_mode_wr, ext0_mode_level, vec_seen, tx_flag, rx_flag, agg, s_agg, s_tx, s_rx;
  core_entry_s core_entry, s_ce;
  logic [7:0] expq[$];
  int num_errors = 0;
  int checked = 0;
  int seed = 18;
  int cycles = 0;

  vectored_interrupt_aggregator u_dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_addr(xdata_addr), .xdata_wr(xdata_wr),
    .xdata_rdata(xdata_rdata), .periph_req(periph_req), .i2c_byte_to_shift(i2c_byte_to_shift),
    .i2c_dout_written(i2c_dout_written), .i2c_byte_loaded(i2c_byte_loaded), .i2c_din_read(i2c_din_read),
    .transmit_empty_flag(tx_flag), .receive_full_flag(rx_flag), .core_req(core_req),
    .ext0_mode_wr(ext0_mode_wr), .ext0_mode_level(ext0_mode_level), .ext0_ack(ext0_ack),
    .aggregated_ext_request(agg), .core_entry(core_entry));

  core_model u_core (.clk_sys(clk_sys), .rst(rst), .service(service), .aggregated_ext_request(agg),
    .xdata_rdata(xdata_rdata), .xdata_addr(xdata_addr), .xdata_wr(xdata_wr), .ext0_mode_wr(ext0_mode_wr),
    .ext0_mode_level(ext0_mode_level), .vec_seen(vec_seen), .vec_val(vec_val));

  always #12.5 clk_sys = ~clk_sys;

  // --------------------------------
  // sampling and checking
  // --------------------------------
  // mid-cycle snapshot so checks at the rising edge never race the design
  always @(negedge clk_sys)
  begin
    s_rd  <= sfr_rdata;
    s_xd  <= xdata_rdata;
    s_agg <= agg;
    s_ce  <= core_entry;
    s_tx  <= tx_flag;
    s_rx  <= rx_flag;
  end

  always @(negedge clk_sys)
  begin
    if (vec_seen === 1'b1 && armed)
    begin
      if (expq.size() == 0)
        cmp({9'h0, vec_val}, 17'h1ffff);
      else
        cmp({9'h0, vec_val}, {9'h0, expq.pop_front()});
    end
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    tick(1);
    sfr_wr <= 1'b0;
    tick(1);
  endtask

  task automatic drain();
    service <= 1'b1;
    for (int i = 0; i < 300 && expq.size() != 0; i++)
      tick(1);
    tick(12);
    service <= 1'b0;
    cmp(17'(expq.size()), 17'h0);
    expq.delete();
  endtask

  task automatic burst(input logic [NSRC-1:0] m);
    periph_req <= m;
    for (int g = 15; g >= 0; g--)
      for (int k = 0; k < NSRC; k++)
        if (m[k] && EXP_VEC[k][7:4] == g)
          expq.push_back(EXP_VEC[k]);
    tick(4);
    cmp({16'h0, s_agg}, {16'h0, m == '0});
    drain();
    cmp({16'h0, s_agg}, 17'h1);
    cmp({9'h0, s_xd}, 17'h0);
    periph_req <= '0;
    tick(2);
  endtask

  task automatic close_out();
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    tick(4);
    rst <= 1'b0;
    tick(3);
    cmp({15'h0, s_tx, s_rx}, 17'h2);
    cmp(s_ce, 17'h0);
    // edge mode: the latched fall is dropped by the ack although the level stays low
    sfr_put(ENABLE_SFR_ADDR, 8'h81);
    tick(1);
    cmp(s_ce, {1'b1, EXP_ENTRY[0]});
    ext0_ack <= 1'b1;
    tick(1);
    ext0_ack <= 1'b0;
    tick(2);
    cmp(s_ce, 17'h0);
    sfr_put(ENABLE_SFR_ADDR, 8'h00);
    i2c_dout_written <= 1'b1;
    tick(1);
    i2c_dout_written <= 1'b0;
    service <= 1'b1;
    tick(30);
    service <= 1'b0;
    armed <= 1'b1;
    sfr_addr <= ENABLE_SFR_ADDR;
    tick(2);
    cmp({9'h0, s_xd}, 17'h0);
    cmp({9'h0, s_rd}, 17'h0);
    sfr_put(ENABLE_SFR_ADDR, 8'hff);
    tick(1);
    cmp({9'h0, s_rd}, 17'h9f);
    sfr_addr <= 8'ha9;
    tick(2);
    cmp({9'h0, s_rd}, 17'h0);
    for (int i = 1; i < NCORE; i++)
    begin
      core_req <= 4'(1 << (i - 1));
      sfr_put(ENABLE_SFR_ADDR, 8'(1 << i));
      tick(2);
      cmp(s_ce, 17'h0);
      sfr_put(ENABLE_SFR_ADDR, 8'h80 | 8'(1 << i));
      tick(2);
      cmp(s_ce, {1'b1, EXP_ENTRY[i]});
    end
    core_req <= '0;
    sfr_put(ENABLE_SFR_ADDR, 8'h81);
    periph_req[20] <= 1'b1;
    expq.push_back(8'h80);
    tick(5);
    cmp(s_ce, {1'b1, EXP_ENTRY[0]});
    drain();
    tick(3);
    cmp(s_ce, 17'h0);
    periph_req <= '0;
    tick(2);
    burst(22'h3fcfff);
    repeat (8) burst(22'($random(seed)) & 22'h3fcfff);
    periph_req[2] <= 1'b1;
    tick(2);
    periph_req[0] <= 1'b1;
    expq.push_back(8'h16);
    expq.push_back(8'h12);
    tick(4);
    drain();
    periph_req <= '0;
    i2c_byte_to_shift <= 1'b1;
    i2c_byte_loaded <= 1'b1;
    expq.push_back(8'h40);
    expq.push_back(8'h42);
    tick(1);
    i2c_byte_to_shift <= 1'b0;
    i2c_byte_loaded <= 1'b0;
    tick(3);
    cmp({15'h0, s_tx, s_rx}, 17'h3);
    drain();
    i2c_din_read <= 1'b1;
    i2c_dout_written <= 1'b1;
    tick(1);
    i2c_din_read <= 1'b0;
    i2c_dout_written <= 1'b0;
    tick(2);
    cmp({15'h0, s_tx, s_rx}, 17'h0);
    close_out();
  end
endmodule
